/* File: fsp_pkg.sv */
/*
  Package for the flash status/configuration protection block: command
  codes, register bit positions, reset values and shared types.
  Assumes a serial link of mode 0/3 framing, MSB first, on its own clock.
*/
package fsp_pkg;

  // command codes
  localparam logic [7:0] CMD_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_WRSR2 = 8'h31;
  localparam logic [7:0] CMD_WRCR = 8'h11;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] CMD_RDSR2 = 8'h35;
  localparam logic [7:0] CMD_RDCR = 8'h15;
  localparam logic [7:0] CMD_SUSP = 8'h75;
  localparam logic [7:0] CMD_SUSP2 = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_RESUME2 = 8'h30;
  localparam logic [7:0] CMD_RSTEN = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;
  localparam logic [7:0] CMD_DPD = 8'hB9;
  localparam logic [7:0] CMD_RDP = 8'hB9;  // release shares the entry code, so it toggles
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_QPP = 8'h32;
  localparam logic [7:0] CMD_PE = 8'h81;
  localparam logic [7:0] CMD_SE = 8'h20;
  localparam logic [7:0] CMD_BE = 8'hD8;
  localparam logic [7:0] CMD_CE = 8'h60;
  localparam logic [7:0] CMD_CE2 = 8'hC7;
  localparam logic [7:0] CMD_ERSCUR = 8'h44;
  localparam logic [7:0] CMD_PRSCUR = 8'h42;
  localparam logic [7:0] CMD_QREAD = 8'h6B;
  localparam logic [7:0] CMD_DIO_READ = 8'hBB;
  localparam logic [7:0] CMD_QIO_READ = 8'hEB;
  localparam logic [7:0] CMD_QPI_EN = 8'h38;

  // status word bit positions
  localparam int SR_BUSY = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_BP_HI = 6;
  localparam int SR_SREG_PROTECT_MODE_LO = 7;
  localparam int SR_SREG_PROTECT_MODE_HI = 8;
  localparam int SR_QE = 9;
  localparam int SR_PSUS = 10;
  localparam int SR_LB_LO = 11;
  localparam int SR_LB_HI = 13;
  localparam int SR_CMP = 14;
  localparam int SR_ESUS = 15;
  // bits that a status write may store directly (lock bits are only OR-ed in, the rest are hardware-owned)
  localparam logic [15:0] SR_WR_MASK = 16'h43FC;
  localparam logic [15:0] SR_RESET = 16'h0000;

  // config byte bit positions
  localparam int CR_DC = 0;
  localparam int CR_PAGE = 4;
  localparam int CR_DRV_LO = 5;
  localparam int CR_DRV_HI = 6;
  localparam logic [7:0] CR_WR_MASK = 8'h71;
  localparam logic [7:0] CR_RESET = 8'h60;

  // dummy counts and page sizes
  localparam logic [3:0] DUMMY_DIO_0 = 4'h4;
  localparam logic [3:0] DUMMY_DIO_1 = 4'h8;
  localparam logic [3:0] DUMMY_QIO_0 = 4'h6;
  localparam logic [3:0] DUMMY_QIO_1 = 4'hA;
  localparam logic [9:0] PAGE_MASK_SMALL = 10'h0FF;
  localparam logic [9:0] PAGE_MASK_LARGE = 10'h3FF;

  // drive strength codes, percent
  localparam logic [6:0] DRV_PCT_00 = 7'h50;
  localparam logic [6:0] DRV_PCT_01 = 7'h28;
  localparam logic [6:0] DRV_PCT_10 = 7'h64;
  localparam logic [6:0] DRV_PCT_11 = 7'h3C;

  // command handed from link domain to core domain
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data0;
    logic [7:0] data1;
    logic [2:0] nbytes;  // bytes seen, saturating at 4
    logic aligned;       // frame ended on a byte boundary
    logic four_wire;     // opcode arrived in four-wire mode
  } fsp_cmd_t;

  // outward configuration view
  typedef struct packed {
    logic [6:0] drive_pct;
    logic [3:0] dummy_dio;
    logic [3:0] dummy_qio;
    logic [9:0] page_mask;
    logic quad_pins;
    logic wp_active;
  } fsp_cfg_t;

endpackage

/* File: fsp_protect.sv */
/*
  Status and configuration protection core of a serial flash.
  Assumes: link logic runs on link_clk_in (serial clock, stops outside
  frames); frame end is the rising edge of the select pin, which is also
  synchronised into sys_clk_in to finish a command. Array, security
  registers and timing engines are outside; this block grants or refuses.
*/
// Functional notes
// - protect mode 00: status write needs only the write latch set
// - mode 01 with protect pin low: status write refused
// - mode 01 with protect pin high: status write needs write latch
// - mode 10: status write refused until power cycle; power cycle gives 00
// - mode 11: status write refused forever, any pin level; reset here still returns mode bits to 00
// - quad enable 1 turns protect and pause pins into data pins
// - three lock bits reset to 0, set individually, never clear; reset here still clears them
// - set lock bit forbids program and erase of its security register
// - complement bit is stored, default 0, steers protected region
// - suspend sets erase-suspended or program-suspended flag
// - resume, reset pair 66 then 99, or power cycle clear both flags
// - large page bit default 0 is 256 bytes, 1 is 1024 bytes
// - load address wraps at 256 unless large page is selected
// - page erase with large page erases the whole 1024-byte page
// - drive field: 00 80%, 01 40%, 10 100%, 11 60% default
// - dual io read dummy count 4 or 8 from dummy select
// - quad io read dummy count 6 or 10 from dummy select
// - power-up puts command state machine in standby
// - data-changing command must be whole bytes, else not run
// - protect pin low in hardware mode freezes complement, bp, mode bits
// - in deep power-down only the release command is obeyed
// - program or erase touching protected range is ignored
// - quad commands and four-wire mode need quad enable
// - write latch clear refuses status write, program and erase
module fsp_protect (
  // system clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // serial link
  input wire logic link_clk_in,
  input wire logic sel_n_in,
  input wire logic [3:0] io_in,
  input wire logic wp_n_in,
  // array interface
  input wire logic busy_in,
  input wire logic [2:0] addr_hit_prot_in,
  input wire logic range_protected_in,
  input wire logic [1:0] sec_reg_sel_in,
  output logic exec_out,
  output logic [7:0] exec_opcode_out,
  output logic exec_erase_large_out,
  output logic erase_suspended_out,
  output logic program_suspended_out,
  // configuration view
  output fsp_pkg::fsp_cfg_t cfg_out,
  output logic [15:0] status_word_out,
  output logic [7:0] config_byte_out,
  output logic [4:0] block_protect_out,
  output logic protect_complement_out,
  output logic deep_pd_out
);

  typedef enum logic [2:0] {
    FSP_STANDBY = 3'b001,
    FSP_DECODE = 3'b010,
    FSP_SLEEP = 3'b100
  } fsp_state_t;

  // link domain: shifter, reset on select high so each frame starts clean
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic [2:0] byte_cnt;
  fsp_pkg::fsp_cmd_t link_cmd;
  logic link_qpi;
  logic [7:0] next_byte;
  logic byte_done;

  // four-wire mode flag crosses into the link domain
  logic qpi_mode;
  logic qpi_s1;
  logic qpi_s2;

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      qpi_s1 <= 1'b0;
      qpi_s2 <= 1'b0;
    end else begin
      qpi_s1 <= qpi_mode;
      qpi_s2 <= qpi_s1;
    end
  end
  assign link_qpi = qpi_s2;

  // next shift value and byte completion on this edge
  assign next_byte = link_qpi ? {shift[3:0], io_in} : {shift[6:0], io_in[0]};
  assign byte_done = link_qpi ? (bit_cnt == 3'h4) : (bit_cnt == 3'h7);

  // serial shift, msb first, one or four bits per edge
  always_ff @(posedge link_clk_in or posedge sel_n_in) begin
    if (sel_n_in) begin
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      byte_cnt <= 3'h0;
    end else begin
      shift <= next_byte;
      bit_cnt <= 3'(bit_cnt + (link_qpi ? 3'h4 : 3'h1));
      if (byte_done && byte_cnt != 3'h4) byte_cnt <= 3'(byte_cnt + 3'h1);
    end
  end

  // captured command; select must not clear it, the core reads it after the frame
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_cmd <= '0;
    end else begin
      link_cmd.aligned <= byte_done;
      link_cmd.four_wire <= link_qpi;
      if (byte_done) begin
        if (byte_cnt == 3'h0) begin
          link_cmd.opcode <= next_byte;
        end else if (byte_cnt == 3'h1) begin
          link_cmd.data0 <= next_byte;
        end else if (byte_cnt == 3'h2) begin
          link_cmd.data1 <= next_byte;
        end
        if (byte_cnt != 3'h4) link_cmd.nbytes <= 3'(byte_cnt + 3'h1);
      end else if (bit_cnt == 3'h0 && byte_cnt == 3'h0) begin
        // first edge of a frame: a short frame must not reuse the last opcode
        link_cmd.opcode <= 8'h00;
        link_cmd.nbytes <= 3'h0;
      end
    end
  end

  // select synchronised; its rising edge ends a frame
  logic sel_s1;
  logic sel_s2;
  logic sel_s3;
  logic frame_end;
  logic wp_s1;
  logic wp_s2;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end else begin
      sel_s1 <= sel_n_in;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      wp_s1 <= wp_n_in;
      wp_s2 <= wp_s1;
    end
  end
  // link_cmd is stable while select stays high, so it is read safely here
  assign frame_end = sel_s2 && !sel_s3;

  // core registers
  fsp_state_t state;
  logic [15:0] sreg;
  logic [7:0] creg;
  logic rst_armed;
  logic pin_wp;
  logic wp_low;
  logic sr_allowed;
  logic data_cmd;
  logic quad_cmd;
  logic cmd_ok;
  logic exec_ok;
  logic sec_locked;
  logic [15:0] next_sreg;
  logic [7:0] next_creg;
  fsp_pkg::fsp_cmd_t cmd;

  assign cmd = link_cmd;
  // with quad enable the protect pin is a data pin
  assign pin_wp = !sreg[fsp_pkg::SR_QE];
  assign wp_low = pin_wp && !wp_s2;

  // status write permission from protect mode
  always_comb begin
    sr_allowed = 1'b0;
    case ({sreg[fsp_pkg::SR_SREG_PROTECT_MODE_HI], sreg[fsp_pkg::SR_SREG_PROTECT_MODE_LO]})
      2'b00: sr_allowed = sreg[fsp_pkg::SR_WEL];
      2'b01: sr_allowed = sreg[fsp_pkg::SR_WEL] && !wp_low;
      2'b10: sr_allowed = 1'b0;
      default: sr_allowed = 1'b0;
    endcase
  end

  // classify the finished command
  always_comb begin
    data_cmd = 1'b0;
    quad_cmd = 1'b0;
    case (cmd.opcode)
      fsp_pkg::CMD_PP, fsp_pkg::CMD_QPP, fsp_pkg::CMD_PE, fsp_pkg::CMD_SE,
      fsp_pkg::CMD_BE, fsp_pkg::CMD_CE, fsp_pkg::CMD_CE2,
      fsp_pkg::CMD_ERSCUR, fsp_pkg::CMD_PRSCUR: data_cmd = 1'b1;
      default: data_cmd = 1'b0;
    endcase
    case (cmd.opcode)
      fsp_pkg::CMD_QPP, fsp_pkg::CMD_QREAD, fsp_pkg::CMD_QIO_READ,
      fsp_pkg::CMD_QPI_EN: quad_cmd = 1'b1;
      default: quad_cmd = 1'b0;
    endcase
    cmd_ok = cmd.aligned && (sreg[fsp_pkg::SR_QE] || (!quad_cmd && !cmd.four_wire));
  end

  // status and config write data, honouring mask, length, lock-bit and pin-freeze guards
  always_comb begin
    next_sreg = sreg;
    next_creg = creg;
    if (cmd.opcode == fsp_pkg::CMD_WRCR) begin
      next_creg = (creg & ~fsp_pkg::CR_WR_MASK) | (cmd.data0 & fsp_pkg::CR_WR_MASK);
    end else begin
      next_sreg = (sreg & ~fsp_pkg::SR_WR_MASK) | ({cmd.data1, cmd.data0} & fsp_pkg::SR_WR_MASK);
      if (cmd.nbytes < 3'h3) begin
        next_sreg[15:8] = sreg[15:8];
      end
      next_sreg[fsp_pkg::SR_LB_HI:fsp_pkg::SR_LB_LO] = sreg[fsp_pkg::SR_LB_HI:fsp_pkg::SR_LB_LO]
        | (cmd.nbytes >= 3'h3 ? cmd.data1[5:3] : 3'h0);
      // hardware mode with pin low freezes these
      if (sreg[fsp_pkg::SR_SREG_PROTECT_MODE_LO] && wp_low) begin
        next_sreg[fsp_pkg::SR_CMP] = sreg[fsp_pkg::SR_CMP];
        next_sreg[fsp_pkg::SR_BP_HI:fsp_pkg::SR_BP_LO] = sreg[fsp_pkg::SR_BP_HI:fsp_pkg::SR_BP_LO];
        next_sreg[fsp_pkg::SR_SREG_PROTECT_MODE_HI] = sreg[fsp_pkg::SR_SREG_PROTECT_MODE_HI];
        next_sreg[fsp_pkg::SR_SREG_PROTECT_MODE_LO] = sreg[fsp_pkg::SR_SREG_PROTECT_MODE_LO];
      end
    end
  end

  // command state machine
  // reset puts it in standby
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= FSP_STANDBY;
    end else begin
      case (state)
        FSP_STANDBY: if (frame_end) state <= FSP_DECODE;
        FSP_DECODE: begin
          if (cmd_ok && cmd.nbytes == 3'h1 && cmd.opcode == fsp_pkg::CMD_DPD && !busy_in) begin
            state <= FSP_SLEEP;
          end else begin
            state <= FSP_STANDBY;
          end
        end
        FSP_SLEEP: begin
          if (frame_end && cmd.aligned && cmd.opcode == fsp_pkg::CMD_RDP) state <= FSP_STANDBY;
        end
        default: state <= FSP_STANDBY;
      endcase
    end
  end

  // status and configuration updates
  // power cycle returns mode bits to 00 via reset value
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sreg <= fsp_pkg::SR_RESET;
      creg <= fsp_pkg::CR_RESET;
      rst_armed <= 1'b0;
      qpi_mode <= 1'b0;
    end else begin
      sreg[fsp_pkg::SR_BUSY] <= busy_in;
      if (state == FSP_DECODE && cmd_ok) begin
        rst_armed <= (cmd.opcode == fsp_pkg::CMD_RSTEN);
        case (cmd.opcode)
          fsp_pkg::CMD_WRITE_ENABLE_CMD: sreg[fsp_pkg::SR_WEL] <= 1'b1;
          fsp_pkg::CMD_WRDI: sreg[fsp_pkg::SR_WEL] <= 1'b0;
          fsp_pkg::CMD_WRSR, fsp_pkg::CMD_WRSR2, fsp_pkg::CMD_WRCR: begin
            if (sr_allowed && cmd.nbytes >= 3'h2 && !busy_in) begin
              sreg <= {next_sreg[15:2], 1'b0, busy_in};
              creg <= next_creg;
            end
          end
          fsp_pkg::CMD_SUSP, fsp_pkg::CMD_SUSP2: begin
            if (busy_in && sreg[fsp_pkg::SR_WEL] == 1'b0) begin
              sreg[fsp_pkg::SR_ESUS] <= 1'b1;
            end else if (busy_in) begin
              sreg[fsp_pkg::SR_PSUS] <= 1'b1;
            end
          end
          fsp_pkg::CMD_RESUME, fsp_pkg::CMD_RESUME2: begin
            sreg[fsp_pkg::SR_ESUS] <= 1'b0;
            sreg[fsp_pkg::SR_PSUS] <= 1'b0;
          end
          fsp_pkg::CMD_RST: begin
            // reset pair clears flags, volatile page bit
            if (rst_armed) begin
              sreg[fsp_pkg::SR_ESUS] <= 1'b0;
              sreg[fsp_pkg::SR_PSUS] <= 1'b0;
              sreg[fsp_pkg::SR_WEL] <= 1'b0;
              creg[fsp_pkg::CR_PAGE] <= 1'b0;
              qpi_mode <= 1'b0;
            end
          end
          fsp_pkg::CMD_QPI_EN: qpi_mode <= 1'b1;
          8'hFF: qpi_mode <= 1'b0;
          default: begin
            // granted data-changing command consumes the write latch
            if (data_cmd && exec_ok) sreg[fsp_pkg::SR_WEL] <= 1'b0;
          end
        endcase
      end else if (state == FSP_DECODE) begin
        rst_armed <= 1'b0;
      end
    end
  end

  // execution grant for program and erase
  // lock bit guards its security register
  assign sec_locked = (sec_reg_sel_in != 2'h0)
    && sreg[fsp_pkg::SR_LB_LO + 32'(sec_reg_sel_in) - 1];
  always_comb begin
    exec_ok = cmd_ok && data_cmd && sreg[fsp_pkg::SR_WEL] && !busy_in;  // latch
    // aligned, latch was set by the host
    if (cmd.opcode == fsp_pkg::CMD_ERSCUR || cmd.opcode == fsp_pkg::CMD_PRSCUR) begin
      exec_ok = exec_ok && !sec_locked;
    end else begin
      exec_ok = exec_ok && !range_protected_in && addr_hit_prot_in == 3'h0;
    end
  end

  // registered grant outputs
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      exec_out <= 1'b0;
      exec_opcode_out <= 8'h00;
      exec_erase_large_out <= 1'b0;
    end else begin
      exec_out <= (state == FSP_DECODE) && exec_ok;
      if ((state == FSP_DECODE) && exec_ok) begin
        exec_opcode_out <= cmd.opcode;
        // large page erase covers 1024 bytes
        exec_erase_large_out <= (cmd.opcode == fsp_pkg::CMD_PE) && creg[fsp_pkg::CR_PAGE];
      end
    end
  end

  // configuration outputs from flip-flops
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_out <= '0;
    end else begin
      case (creg[fsp_pkg::CR_DRV_HI:fsp_pkg::CR_DRV_LO])
        2'b00: cfg_out.drive_pct <= fsp_pkg::DRV_PCT_00;
        2'b01: cfg_out.drive_pct <= fsp_pkg::DRV_PCT_01;
        2'b10: cfg_out.drive_pct <= fsp_pkg::DRV_PCT_10;
        default: cfg_out.drive_pct <= fsp_pkg::DRV_PCT_11;
      endcase
      cfg_out.dummy_dio <= creg[fsp_pkg::CR_DC] ? fsp_pkg::DUMMY_DIO_1 : fsp_pkg::DUMMY_DIO_0;
      cfg_out.dummy_qio <= creg[fsp_pkg::CR_DC] ? fsp_pkg::DUMMY_QIO_1 : fsp_pkg::DUMMY_QIO_0;
      cfg_out.page_mask <= creg[fsp_pkg::CR_PAGE] ? fsp_pkg::PAGE_MASK_LARGE
                                                  : fsp_pkg::PAGE_MASK_SMALL;
      cfg_out.quad_pins <= sreg[fsp_pkg::SR_QE];
      cfg_out.wp_active <= pin_wp;
    end
  end

  // status views, straight from registers
  assign status_word_out = sreg;
  assign config_byte_out = creg;
  // complement with block protect selects region
  assign block_protect_out = sreg[fsp_pkg::SR_BP_HI:fsp_pkg::SR_BP_LO];
  assign protect_complement_out = sreg[fsp_pkg::SR_CMP];
  assign erase_suspended_out = sreg[fsp_pkg::SR_ESUS];
  assign program_suspended_out = sreg[fsp_pkg::SR_PSUS];
  assign deep_pd_out = (state == FSP_SLEEP);

endmodule

/* File: fsp_assertions.sv */
/*
  Checker for the protection core, bound to its top ports.
  Assumes one system clock domain and a cfg view registered one edge late.
*/
module fsp_assertions (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // watched ports
  input wire logic wp_n_in,
  input wire logic exec_out,
  input wire fsp_pkg::fsp_cfg_t cfg_out,
  input wire logic [15:0] status_word_out,
  input wire logic [7:0] config_byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  // percent for a drive code, written out independently of the package
  function automatic logic [6:0] pct(input logic [1:0] d);
    case (d)
      2'h0: return 7'h50;
      2'h1: return 7'h28;
      2'h2: return 7'h64;
      default: return 7'h3C;
    endcase
  endfunction

  a_exec_single_pulse: assert property (
    exec_out |=> !exec_out) else $error("grant pulse longer than one cycle");
  a_reset_values: assert property (
    $rose(rstn_in) |-> status_word_out == 16'h0000 && config_byte_out == 8'h60)
    else $error("registers not at reset values after release");
  a_lock_sticky: assert property (
    ($past(status_word_out[13:11]) & ~status_word_out[13:11]) == 3'h0)
    else $error("lock bit cleared");
  a_otp_frozen: assert property (
    status_word_out[8:7] == 2'b11 |=> $stable(status_word_out[14]) && $stable(status_word_out[9:2]))
    else $error("status changed in permanent protect mode");
  a_lockdown_frozen: assert property (
    status_word_out[8:7] == 2'b10 |=>
      (status_word_out & 16'h43FC) == ($past(status_word_out) & 16'h43FC))
    else $error("status changed in lock-down mode");
  a_pin_locked: assert property (
    (!wp_n_in)[*4] ##0 (status_word_out[8:7] == 2'b01 && !status_word_out[9]) |=>
      $stable(status_word_out[8:2]) && $stable(status_word_out[14]))
    else $error("status changed while protect pin low");
  a_drive_map: assert property (
    $past(rstn_in) |-> cfg_out.drive_pct == pct($past(config_byte_out[6:5])))
    else $error("drive strength does not follow drive field");
  a_dummy_map: assert property (
    $past(rstn_in) |-> {cfg_out.dummy_dio, cfg_out.dummy_qio} ==
      ($past(config_byte_out[0]) ? 8'h8A : 8'h46))
    else $error("dummy counts do not follow dummy select");
  a_page_map: assert property (
    $past(rstn_in) |-> cfg_out.page_mask == ($past(config_byte_out[4]) ? 10'h3FF : 10'h0FF))
    else $error("page wrap does not follow page select");
endmodule

bind fsp_protect fsp_assertions chk (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .wp_n_in(wp_n_in), .exec_out(exec_out),
  .cfg_out(cfg_out), .status_word_out(status_word_out), .config_byte_out(config_byte_out)
);

/* File: fsp_host_model.sv */
/*
  Host side of the serial link: shifts frames MSB first on io_out[0].
  Assumes the bench calls send; the link clock stands low between frames.
*/
module fsp_host_model (
  // serial link
  output logic link_clk_out,
  output logic sel_n_out,
  output logic [3:0] io_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle link
  initial begin
    link_clk_out = 1'b0;
    sel_n_out = 1'b1;
    io_out = 4'h5;
  end
  // one frame; cut drops the last bit to break byte alignment
  task automatic send(input logic [31:0] frame, input int nbytes, input bit cut);
    int nbits;
    nbits = nbytes * 8 - int'(cut);
    sel_n_out = 1'b0;
    #20;
    for (int i = 0; i < nbits; i++) begin
      io_out = {~io_out[3:1], frame[31 - i]};
      #24 link_clk_out = 1'b1;
      #24 link_clk_out = 1'b0;
    end
    #20 sel_n_out = 1'b1;
    // released lines flip so a held value is never mistaken for data
    io_out = ~io_out;
    #100;
  endtask
endmodule

/* File: fsp_tb.sv */
/*
  Self-checking bench for the protection core: status and config writes,
  protect modes, suspend flags and program grants, random data.
  Assumes the host model for link traffic and the bound checker.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic wp_n_in = 1'b1;
  logic busy_in = 1'b0;
  logic range_protected_in = 1'b0;
  logic [2:0] addr_hit_prot_in = 3'h0;
  logic [1:0] sec_reg_sel_in = 2'h1;
  logic link_clk_in, sel_n_in, exec_out, exec_erase_large_out, erase_suspended_out;
  logic program_suspended_out, protect_complement_out, deep_pd_out;
  logic [3:0] io_in;
  logic [7:0] exec_opcode_out, config_byte_out;
  logic [15:0] status_word_out, exp_sr, v;
  logic [4:0] block_protect_out;
  fsp_pkg::fsp_cfg_t cfg_out;
  int n_fail = 0;
  int num_checks = 0;
  int n_exec = 0;
  int n;
  bit exp_go;

`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %0t: %h seen, %h expected", $time, (got), (exp)); end end

  fsp_host_model host (.link_clk_out(link_clk_in), .sel_n_out(sel_n_in), .io_out(io_in));
  fsp_protect uut (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk_in),
    .sel_n_in(sel_n_in), .io_in(io_in), .wp_n_in(wp_n_in), .busy_in(busy_in),
    .addr_hit_prot_in(addr_hit_prot_in), .range_protected_in(range_protected_in),
    .sec_reg_sel_in(sec_reg_sel_in), .exec_out(exec_out), .exec_opcode_out(exec_opcode_out),
    .exec_erase_large_out(exec_erase_large_out), .erase_suspended_out(erase_suspended_out),
    .program_suspended_out(program_suspended_out), .cfg_out(cfg_out),
    .status_word_out(status_word_out), .config_byte_out(config_byte_out),
    .block_protect_out(block_protect_out), .protect_complement_out(protect_complement_out),
    .deep_pd_out(deep_pd_out)
  );

  // 250 MHz system clock
  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // count grants, which are one-cycle pulses
  always @(posedge sys_clk_in) begin
    if (exec_out === 1'b1) n_exec++;
  end

  // write allowed by mode, pin, quad enable
  function automatic bit sr_ok(input logic [15:0] sr, input logic wp);
    case (sr[8:7])
      2'b00: return 1'b1;
      2'b01: return wp | sr[9];
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [6:0] exp_pct(input logic [1:0] d);
    case (d)
      2'h0: return 7'h50;
      2'h1: return 7'h28;
      2'h2: return 7'h64;
      default: return 7'h3C;
    endcase
  endfunction

  task automatic cmd(input logic [7:0] op);
    host.send({op, 24'h0}, 1, 1'b0);
  endtask
  task automatic set_in(input logic b, input logic w);
    @(posedge sys_clk_in);
    busy_in <= b;
    wp_n_in <= w;
    repeat (4) @(posedge sys_clk_in);
  endtask
  task automatic pulse_reset(input int cycles);
    @(posedge sys_clk_in);
    rstn_in <= 1'b0;
    repeat (cycles) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    exp_sr = 16'h0000;
  endtask
  // status write attempt; lock bits can only gain
  task automatic sr_try(input logic [15:0] d, input logic wp, input bit write_enable_cmd, input bit cut);
    set_in(1'b0, wp);
    if (write_enable_cmd) cmd(fsp_pkg::CMD_WRITE_ENABLE_CMD);
    host.send({$urandom_range(1) ? fsp_pkg::CMD_WRSR : fsp_pkg::CMD_WRSR2, d[7:0], d[15:8],
      8'h00}, 3, cut);
    if (write_enable_cmd && !cut && sr_ok(exp_sr, wp)) exp_sr = (exp_sr & ~16'h43FC) | (d & 16'h7BFC);
    `CHECK(status_word_out & 16'h7FFC, exp_sr & 16'h7FFC)
    `CHECK({protect_complement_out, block_protect_out}, {exp_sr[14], exp_sr[6:2]})
    `CHECK({cfg_out.quad_pins, cfg_out.wp_active}, {exp_sr[9], !exp_sr[9]})
  endtask
  task automatic cr_try(input logic [7:0] c);
    cmd(fsp_pkg::CMD_WRITE_ENABLE_CMD);
    host.send({fsp_pkg::CMD_WRCR, c, 16'h0}, 2, 1'b0);
    `CHECK(config_byte_out & 8'h71, c & 8'h71)
    `CHECK(cfg_out.drive_pct, exp_pct(c[6:5]))
    `CHECK({cfg_out.dummy_dio, cfg_out.dummy_qio}, c[0] ? 8'h8A : 8'h46)
    `CHECK(cfg_out.page_mask, c[4] ? 10'h3FF : 10'h0FF)
  endtask
  task automatic sus_check(input logic [7:0] op, input logic b, input logic [1:0] e);
    set_in(b, 1'b1);
    cmd(op);
    `CHECK({erase_suspended_out, program_suspended_out}, e)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard, well beyond the expected run
  initial begin
    #300000;
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // main sequence
  initial begin
    void'($urandom(32'hd216));
    pulse_reset(16);
    `CHECK(status_word_out, 16'h0000)
    `CHECK(config_byte_out, 8'h60)
    `CHECK(cfg_out.page_mask, 10'h0FF)
    sr_try(16'($urandom), 1'b1, 1'b0, 1'b0);
    sr_try(16'($urandom) & 16'hFE7F, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) cr_try({1'b0, i[1:0], 1'($urandom), 3'h0, i[2]});
    for (int i = 0; i < 10; i++) begin
      v = 16'($urandom);
      v[8] = 1'b0;
      sr_try(v, 1'($urandom), 1'b1, 1'b0);
    end
    sr_try(16'h0080, 1'b1, 1'b1, 1'b0);
    sr_try(16'h407C, 1'b0, 1'b1, 1'b0);
    sr_try(16'h00FC, 1'b1, 1'b1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      sus_check(fsp_pkg::CMD_WRDI, 1'b0, 2'b00);
      sus_check(k ? fsp_pkg::CMD_SUSP2 : fsp_pkg::CMD_SUSP, 1'b1, 2'b10);
      sus_check(k ? fsp_pkg::CMD_RESUME2 : fsp_pkg::CMD_RESUME, 1'b1, 2'b00);
      sus_check(fsp_pkg::CMD_WRITE_ENABLE_CMD, 1'b0, 2'b00);
      sus_check(k ? fsp_pkg::CMD_SUSP : fsp_pkg::CMD_SUSP2, 1'b1, 2'b01);
      sus_check(fsp_pkg::CMD_RSTEN, 1'b1, 2'b01);
      sus_check(fsp_pkg::CMD_RST, 1'b1, 2'b00);
    end
    // program grants: protected range, latch clear, locked security register
    for (int i = 0; i < 8; i++) begin
      n = n_exec;
      @(posedge sys_clk_in);
      busy_in <= 1'b0;
      range_protected_in <= i[0] ? 1'b0 : 1'($urandom);
      addr_hit_prot_in <= (i == 6) ? 3'h4 : 3'h0;
      sec_reg_sel_in <= 2'($urandom_range(3, 1));
      repeat (2) @(posedge sys_clk_in);
      cmd(i < 2 ? fsp_pkg::CMD_WRDI : fsp_pkg::CMD_WRITE_ENABLE_CMD);
      host.send({i[0] ? fsp_pkg::CMD_PRSCUR : fsp_pkg::CMD_PP, 24'($urandom)}, 4, 1'b0);
      exp_go = i >= 2 && (i[0] ? !exp_sr[10 + sec_reg_sel_in] :
        !range_protected_in && addr_hit_prot_in == 3'h0);
      `CHECK(n_exec - n, int'(exp_go))
      if (exp_go) `CHECK(exec_opcode_out, i[0] ? fsp_pkg::CMD_PRSCUR : fsp_pkg::CMD_PP)
    end
    // large page erase granted, quad program refused with quad enable clear
    cr_try(8'h11);
    n = n_exec;
    cmd(fsp_pkg::CMD_WRITE_ENABLE_CMD);
    host.send({fsp_pkg::CMD_PE, 24'($urandom)}, 4, 1'b0);
    cmd(fsp_pkg::CMD_WRITE_ENABLE_CMD);
    host.send({fsp_pkg::CMD_QPP, 24'($urandom)}, 4, 1'b0);
    `CHECK(n_exec - n, 1)
    `CHECK({exec_opcode_out, exec_erase_large_out}, {fsp_pkg::CMD_PE, 1'b1})
    // deep power-down ignores a latch clear until released
    cmd(fsp_pkg::CMD_DPD);
    cmd(fsp_pkg::CMD_WRDI);
    `CHECK({deep_pd_out, status_word_out[1]}, 2'b11)
    cmd(fsp_pkg::CMD_RDP);
    `CHECK(deep_pd_out, 1'b0)
    sr_try(16'h0100, 1'b1, 1'b1, 1'b0);
    sr_try(16'h0000, 1'b1, 1'b1, 1'b0);
    pulse_reset(4);
    `CHECK(status_word_out[8:7], 2'b00)
    sr_try(16'h0180, 1'b1, 1'b1, 1'b0);
    sr_try(16'h0000, 1'b0, 1'b1, 1'b0);
    sr_try(16'h0000, 1'b1, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule
